// ===== crps_regs.vh
// register map, field positions and timing constants of the config sequencer
`ifndef CRPS_REGS_VH
`define CRPS_REGS_VH

// sub-addresses on the board bus
`define CRPS_REG_CMD 5'h06
`define CRPS_REG_REBOOT 5'h07
`define CRPS_REG_STATUS 5'h11

// config_command fields
`define CRPS_CMD_TGT_HI 10
`define CRPS_CMD_TGT_LO 9
`define CRPS_CMD_EXEC 8
`define CRPS_CMD_SRAM_SEL 7
`define CRPS_CMD_OP_HI 6
`define CRPS_CMD_OP_LO 3
`define CRPS_CMD_RESET 16'h0000

// config_status fields
`define CRPS_STAT_IDLE 15

// targets and opcodes
`define CRPS_TGT_PRIMARY 2'h1
`define CRPS_TGT_SECONDARY 2'h2
`define CRPS_TGT_CENTRAL 2'h3
`define CRPS_OP_PROG_PRIMARY 4'h0
`define CRPS_OP_PROG_SECONDARY 4'h1
`define CRPS_OP_PROG_CENTRAL 4'h2
`define CRPS_OP_READ_PRIMARY 4'h3
`define CRPS_OP_READ_SECONDARY 4'h4
`define CRPS_OP_READ_CENTRAL 4'h5

// reboot key sequence in reboot_control bits 2..0
`define CRPS_KEY_A 3'h5
`define CRPS_KEY_B 3'h2
`define CRPS_REBOOT_RESET 16'h0000

// serial flash command bytes and status ready bit
`define CRPS_FL_WRITE 8'h02
`define CRPS_FL_READ 8'h03
`define CRPS_FL_STATUS 8'h05
`define CRPS_FL_READY_BIT 7

// timing
`define CRPS_MCLK_MHZ 20
`define CRPS_REBOOT_NS 1000
`define CRPS_REBOOT_CYCLES ((`CRPS_REBOOT_NS * `CRPS_MCLK_MHZ + 999) / 1000)
`define CRPS_SPI_HALF 4

`endif

// ===== crps_spi_byte.v
// one-byte serial shifter, mode 0, for the configuration flash
`timescale 1ns/1ps
`default_nettype none
module crps_spi_byte #(
  parameter HALF = 4
) (
  // clock and reset
  input wire mclk,
  input wire srst,
  // byte request
  input wire start,
  input wire [7:0] tx_byte,
  output reg done,
  output reg [7:0] rx_byte,
  // serial pins
  output reg sclk,
  output wire mosi,
  input wire miso
);

  reg miso_m_reg;
  reg miso_s_reg;
  reg active_reg;
  reg [7:0] shift_reg;
  reg [2:0] bit_reg;
  reg [7:0] cnt_reg;

  // miso is a pin: two flops before use; half period must exceed sync delay
  always @(posedge mclk) begin
    miso_m_reg <= miso;
    miso_s_reg <= miso_m_reg;
  end

  assign mosi = shift_reg[7];

  // sample on rising sclk, shift on falling sclk
  always @(posedge mclk) begin
    if (srst) begin
      active_reg <= 1'b0;
      shift_reg <= 8'h00;
      bit_reg <= 3'h0;
      cnt_reg <= 8'h00;
      sclk <= 1'b0;
      done <= 1'b0;
      rx_byte <= 8'h00;
    end else begin
      done <= 1'b0;
      if (!active_reg) begin
        if (start) begin
          active_reg <= 1'b1;
          shift_reg <= tx_byte;
          bit_reg <= 3'h0;
          cnt_reg <= 8'h00;
        end
      end else if (cnt_reg == HALF - 1) begin
        cnt_reg <= 8'h00;
        sclk <= ~sclk;
        if (!sclk) begin
          rx_byte <= {rx_byte[6:0], miso_s_reg};
        end else begin
          shift_reg <= {shift_reg[6:0], 1'b0};
          bit_reg <= bit_reg + 3'h1;
          if (bit_reg == 3'h7) begin
            active_reg <= 1'b0;
            done <= 1'b1;
          end
        end
      end else begin
        cnt_reg <= cnt_reg + 8'h01;
      end
    end
  end

endmodule // crps_spi_byte
`default_nettype wire

// ===== crps_sequencer.v
// flash program/readback sequencer with idle flag and reboot key
`timescale 1ns/1ps
`default_nettype none
`include "crps_regs.vh"

// Summary of operation
// - Idle flag stays low during a program until all staged data is stored.
// - A read opcode copies the whole flash image to SRAM before idle rises.
// - Writing 101, 010, 101 into reboot bits 2..0 starts a reload of all FPGAs.
// - Reboot reloads all three FPGAs together; no single-FPGA reload exists.
// - An opcode starts only on a zero-to-one change of command bit 8.
// - Status bit 15 is one exactly when the sequencer is idle.
// - Command bits 10..9 pick the flash: 1 primary, 2 secondary, 3 central.
// - With command bit 7 set host accesses go to SRAM and no opcode starts.
module crps_sequencer #(
  parameter AW = 22,
  parameter IMAGE_WORDS = 4194304,
  parameter [14:0] FW_VERSION = 15'h0001 // arbitrary value
) (
  // clock and reset
  input wire mclk,
  input wire srst,
  // register port from the board-bus slave
  input wire [4:0] reg_addr,
  input wire reg_wr,
  input wire [15:0] reg_wdata,
  output reg [15:0] reg_rd_data,
  // staging sram
  output reg [AW-1:0] sram_addr_reg,
  output reg sram_rd_reg,
  output reg sram_we_reg,
  output reg [15:0] sram_wdata_reg,
  input wire [15:0] sram_rdata,
  output reg sram_host_sel_reg,
  // configuration flash, one select per fpga
  output reg [2:0] flash_cs_n_reg,
  output reg flash_sclk_reg,
  output reg flash_mosi_reg,
  input wire flash_miso,
  // reload of all fpgas
  output reg fpga_reload_reg
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_FETCH = 3'h1;
  localparam [2:0] ST_SEND = 3'h2;
  localparam [2:0] ST_POLL = 3'h3;
  localparam [2:0] ST_READ = 3'h4;
  localparam [2:0] ST_GAP = 3'h5;
  localparam [31:0] LAST_WORD_W = IMAGE_WORDS - 1;
  localparam [AW-1:0] LAST_WORD = LAST_WORD_W[AW-1:0]; // cut on purpose to the word counter
  localparam [31:0] RELOAD_LAST_W = `CRPS_REBOOT_CYCLES - 1;
  reg [15:0] cmd_reg, reboot_reg;
  reg exec_prev_reg;
  reg [2:0] state_reg, gap_next_reg;
  reg [AW-1:0] word_reg;
  reg [15:0] data_reg;
  reg [2:0] idx_reg;
  reg hi_reg, wait_reg, fetch_wait_reg, read_job_reg;
  reg [1:0] tgt_reg, key_stage_reg;
  reg [7:0] reload_cnt_reg;
  reg spi_start_reg;
  reg [7:0] spi_tx_reg;
  wire spi_done, spi_sclk, spi_mosi;
  wire [7:0] spi_rx;
  wire [3:0] op;
  wire [1:0] tgt;
  wire op_prog, op_read, start;
  wire [23:0] fl_addr;
  reg [7:0] frame_byte;
  assign op = cmd_reg[`CRPS_CMD_OP_HI:`CRPS_CMD_OP_LO];
  assign tgt = cmd_reg[`CRPS_CMD_TGT_HI:`CRPS_CMD_TGT_LO];
  assign op_prog = (op <= `CRPS_OP_PROG_CENTRAL);
  assign op_read = (op >= `CRPS_OP_READ_PRIMARY) && (op <= `CRPS_OP_READ_CENTRAL);
  // edge only, idle only, never while sram is selected, real target only
  assign start = cmd_reg[`CRPS_CMD_EXEC] & ~exec_prev_reg
               & (state_reg == ST_IDLE)
               & ~cmd_reg[`CRPS_CMD_SRAM_SEL]
               & (tgt != 2'h0) & (op_prog | op_read);
  // flash byte address of the current word
  assign fl_addr = {{(23-AW){1'b0}}, word_reg, 1'b0};
  // bytes of a write or read frame; latched job kind, so a host rewrite mid-job cannot switch it
  always @* begin
    case (idx_reg)
      3'h0: frame_byte = read_job_reg ? `CRPS_FL_READ : `CRPS_FL_WRITE;
      3'h1: frame_byte = fl_addr[23:16];
      3'h2: frame_byte = fl_addr[15:8];
      3'h3: frame_byte = fl_addr[7:0];
      3'h4: frame_byte = read_job_reg ? 8'h00 : data_reg[15:8];
      3'h5: frame_byte = read_job_reg ? 8'h00 : data_reg[7:0];
      default: frame_byte = 8'h00;
    endcase
  end

  crps_spi_byte #(.HALF(`CRPS_SPI_HALF)) u_spi (
    .mclk(mclk),
    .srst(srst),
    .start(spi_start_reg),
    .tx_byte(spi_tx_reg),
    .done(spi_done),
    .rx_byte(spi_rx),
    .sclk(spi_sclk),
    .mosi(spi_mosi),
    .miso(flash_miso)
  );

  // registers, read mux and reboot key detector
  always @(posedge mclk) begin
    if (srst) begin
      cmd_reg <= `CRPS_CMD_RESET;
      reboot_reg <= `CRPS_REBOOT_RESET;
      exec_prev_reg <= 1'b0;
      key_stage_reg <= 2'h0;
      reload_cnt_reg <= 8'h00;
      fpga_reload_reg <= 1'b0;
      reg_rd_data <= 16'h0000;
      sram_host_sel_reg <= 1'b0;
    end else begin
      exec_prev_reg <= cmd_reg[`CRPS_CMD_EXEC];
      sram_host_sel_reg <= cmd_reg[`CRPS_CMD_SRAM_SEL];
      if (reg_wr && reg_addr == `CRPS_REG_CMD) begin
        cmd_reg <= reg_wdata;
      end
      if (reload_cnt_reg != 8'h00) begin
        reload_cnt_reg <= reload_cnt_reg - 8'h01;
      end else begin
        fpga_reload_reg <= 1'b0;
      end
      // a wrong value restarts the key; a lone first value counts as step one
      if (reg_wr && reg_addr == `CRPS_REG_REBOOT) begin
        reboot_reg <= reg_wdata;
        if (reg_wdata[2:0] == `CRPS_KEY_A && key_stage_reg == 2'h2) begin
          key_stage_reg <= 2'h0;
          fpga_reload_reg <= 1'b1;
          reload_cnt_reg <= RELOAD_LAST_W[7:0];
        end else if (reg_wdata[2:0] == `CRPS_KEY_B && key_stage_reg == 2'h1) begin
          key_stage_reg <= 2'h2;
        end else if (reg_wdata[2:0] == `CRPS_KEY_A) begin
          key_stage_reg <= 2'h1;
        end else begin
          key_stage_reg <= 2'h0;
        end
      end
      // unmapped sub-addresses read zero
      case (reg_addr)
        `CRPS_REG_CMD: reg_rd_data <= cmd_reg;
        `CRPS_REG_REBOOT: reg_rd_data <= reboot_reg;
        `CRPS_REG_STATUS: reg_rd_data <= {(state_reg == ST_IDLE), FW_VERSION};
        default: reg_rd_data <= 16'h0000;
      endcase
    end
  end

  // transfer engine: program writes one word per frame then polls ready
  always @(posedge mclk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
      gap_next_reg <= ST_IDLE;
      word_reg <= {AW{1'b0}};
      data_reg <= 16'h0000;
      idx_reg <= 3'h0;
      hi_reg <= 1'b0;
      wait_reg <= 1'b0;
      fetch_wait_reg <= 1'b0;
      tgt_reg <= 2'h0;
      read_job_reg <= 1'b0;
      spi_start_reg <= 1'b0;
      spi_tx_reg <= 8'h00;
      flash_cs_n_reg <= 3'h7;
      flash_sclk_reg <= 1'b0;
      flash_mosi_reg <= 1'b0;
      sram_addr_reg <= {AW{1'b0}};
      sram_rd_reg <= 1'b0;
      sram_we_reg <= 1'b0;
      sram_wdata_reg <= 16'h0000;
    end else begin
      spi_start_reg <= 1'b0;
      sram_rd_reg <= 1'b0;
      sram_we_reg <= 1'b0;
      flash_sclk_reg <= spi_sclk;
      flash_mosi_reg <= spi_mosi;
      case (state_reg)
        ST_IDLE: begin
          if (start) begin
            tgt_reg <= tgt;
            read_job_reg <= op_read;
            word_reg <= {AW{1'b0}};
            idx_reg <= 3'h0;
            hi_reg <= 1'b1;
            state_reg <= op_read ? ST_GAP : ST_FETCH;
            gap_next_reg <= ST_READ;
          end
        end
        ST_FETCH: begin
          // sram data is taken one cycle after the read strobe
          if (!fetch_wait_reg) begin
            sram_addr_reg <= word_reg;
            sram_rd_reg <= 1'b1;
            fetch_wait_reg <= 1'b1;
          end else if (!sram_rd_reg) begin
            data_reg <= sram_rdata;
            fetch_wait_reg <= 1'b0;
            idx_reg <= 3'h0;
            state_reg <= ST_GAP;
            gap_next_reg <= ST_SEND;
          end
        end
        ST_GAP: begin
          // one cycle with all selects high separates frames
          flash_cs_n_reg <= ~(3'h1 << (tgt_reg - 2'h1));
          state_reg <= gap_next_reg;
        end
        ST_SEND: begin
          if (!wait_reg) begin
            spi_tx_reg <= frame_byte;
            spi_start_reg <= 1'b1;
            wait_reg <= 1'b1;
          end else if (spi_done) begin
            wait_reg <= 1'b0;
            idx_reg <= idx_reg + 3'h1;
            if (idx_reg == 3'h5) begin
              flash_cs_n_reg <= 3'h7;
              idx_reg <= 3'h0;
              state_reg <= ST_GAP;
              gap_next_reg <= ST_POLL;
            end
          end
        end
        ST_POLL: begin
          // idle stays low until the flash reports the write stored
          if (!wait_reg) begin
            spi_tx_reg <= (idx_reg == 3'h0) ? `CRPS_FL_STATUS : 8'h00;
            spi_start_reg <= 1'b1;
            wait_reg <= 1'b1;
          end else if (spi_done) begin
            wait_reg <= 1'b0;
            idx_reg <= 3'h1;
            if (idx_reg != 3'h0) begin
              flash_cs_n_reg <= 3'h7;
              idx_reg <= 3'h0;
              state_reg <= ST_GAP;
              gap_next_reg <= ST_POLL;
              if (spi_rx[`CRPS_FL_READY_BIT]) begin
                if (word_reg == LAST_WORD) begin
                  state_reg <= ST_IDLE;
                end else begin
                  word_reg <= word_reg + {{(AW-1){1'b0}}, 1'b1};
                  state_reg <= ST_FETCH;
                end
              end
            end
          end
        end
        ST_READ: begin
          // one continuous frame streams the whole image into sram
          if (!wait_reg) begin
            spi_tx_reg <= frame_byte;
            spi_start_reg <= 1'b1;
            wait_reg <= 1'b1;
          end else if (spi_done) begin
            wait_reg <= 1'b0;
            if (idx_reg != 3'h4) begin
              idx_reg <= idx_reg + 3'h1;
            end else if (hi_reg) begin
              data_reg[15:8] <= spi_rx;
              hi_reg <= 1'b0;
            end else begin
              hi_reg <= 1'b1;
              sram_addr_reg <= word_reg;
              sram_wdata_reg <= {data_reg[15:8], spi_rx};
              sram_we_reg <= 1'b1;
              word_reg <= word_reg + {{(AW-1){1'b0}}, 1'b1};
              if (word_reg == LAST_WORD) begin
                flash_cs_n_reg <= 3'h7;
                state_reg <= ST_IDLE;
              end
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // crps_sequencer
`default_nettype wire

// ===== crps_monitor_monitor.sv
// port checker for the config sequencer
`timescale 1ns/1ps
`default_nettype none
module crps_monitor #(
  parameter [14:0] FW_VERSION = 15'h0001
) (
  // clock and reset
  input wire mclk,
  input wire srst,
  // register port
  input wire [4:0] reg_addr,
  input wire reg_wr,
  input wire [15:0] reg_wdata,
  input wire [15:0] reg_rd_data,
  // sram, flash, reload
  input wire sram_host_sel_reg,
  input wire [2:0] flash_cs_n_reg,
  input wire flash_sclk_reg,
  input wire fpga_reload_reg
);
  localparam int RB = 20;
  reg [5:0] rl_cnt_reg;
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  // cycles the reload pulse has stood
  always @(posedge mclk) begin
    rl_cnt_reg <= (srst || !fpga_reload_reg) ? 6'h00 : rl_cnt_reg + 6'h01;
  end
  property p_one_flash;
    $onehot0(~flash_cs_n_reg);
  endproperty
  a_one_flash: assert property (p_one_flash) else $error("two flash selects");
  property p_sclk_rest;
    flash_cs_n_reg == 3'h7 |-> !flash_sclk_reg;
  endproperty
  a_sclk_rest: assert property (p_sclk_rest) else $error("sclk not idle");
  property p_busy;
    $past(flash_cs_n_reg) != 3'h7 && $past(reg_addr) == 5'h11 |-> !reg_rd_data[15];
  endproperty
  a_busy: assert property (p_busy) else $error("idle while flash busy");
  property p_fw;
    $past(reg_addr) == 5'h11 && !$past(srst) |-> reg_rd_data[14:0] == FW_VERSION;
  endproperty
  a_fw: assert property (p_fw) else $error("status version");
  property p_sel_sram;
    reg_wr && reg_addr == 5'h06 |-> ##2 sram_host_sel_reg == $past(reg_wdata[7], 2);
  endproperty
  a_sel_sram: assert property (p_sel_sram) else $error("sram select");
  property p_rl_cause;
    $rose(fpga_reload_reg) |-> $past(reg_wr) && $past(reg_addr) == 5'h07
      && $past(reg_wdata[2:0]) == 3'h5;
  endproperty
  a_rl_cause: assert property (p_rl_cause) else $error("reload cause");
  property p_rl_len;
    $fell(fpga_reload_reg) |-> rl_cnt_reg == RB;
  endproperty
  a_rl_len: assert property (p_rl_len) else $error("reload short");
  property p_rl_max;
    fpga_reload_reg |-> rl_cnt_reg < RB;
  endproperty
  a_rl_max: assert property (p_rl_max) else $error("reload long");
endmodule // crps_monitor
bind crps_sequencer crps_monitor #(.FW_VERSION(FW_VERSION)) i_crps_monitor (.mclk, .srst,
  .reg_addr, .reg_wr, .reg_wdata, .reg_rd_data, .sram_host_sel_reg, .flash_cs_n_reg,
  .flash_sclk_reg, .fpga_reload_reg);
`default_nettype wire

// ===== crps_flash_model.sv
// serial config flash model, mode 0
`timescale 1ns/1ps
`default_nettype none
module crps_flash_model (
  // serial pins
  input wire [2:0] cs_n,
  input wire sclk,
  input wire mosi,
  output logic miso
);
  logic [7:0] sh, cmd, hi, tx;
  logic [23:0] adr;
  logic [15:0] mem [0:15];
  int bits = 0;
  int nb = 0;
  int polls = 0;
  initial miso = 1'b0;
  // shift in on rising clock
  always @(posedge sclk) if (cs_n != 3'h7) begin
    sh = {sh[6:0], mosi};
    bits = bits + 1;
    if (bits == 8) begin
      bits = 0;
      if (nb == 0) cmd = sh;
      else if (nb < 4) adr = {adr[15:0], sh};
      else if (nb == 4) hi = sh;
      else if (nb == 5 && cmd == 8'h02) mem[adr[4:1]] = {hi, sh};
      nb = nb + 1;
    end
  end
  // replies on falling clock; status busy every other poll
  always @(negedge sclk) if (cs_n != 3'h7) begin
    if (bits == 0) begin
      tx = (cmd == 8'h05) ? {polls[0], 7'h00} : 8'h3C ^ 8'(nb - 4);
      if (cmd == 8'h05 && nb == 1) polls = polls + 1;
    end
    miso <= tx[7 - bits];
  end
  // deselected: frame over, line turns so stale data never reads right
  always @(cs_n) if (cs_n == 3'h7) begin
    bits = 0;
    nb = 0;
    miso <= ~miso;
  end
endmodule // crps_flash_model
`default_nettype wire

// ===== tb.sv
// bench: host traffic, sram and flash models
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int NW = 4;
  localparam [14:0] FW = 15'h0001; // arbitrary value
  logic mclk = 0;
  logic srst = 1;
  logic reg_wr = 0;
  logic [4:0] reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] sram_rdata = 16'h0000;
  wire [15:0] reg_rd_data, sram_wdata_reg;
  wire [21:0] sram_addr_reg;
  wire [2:0] flash_cs_n_reg;
  wire sram_rd_reg, sram_we_reg, sram_host_sel_reg, flash_sclk_reg, flash_mosi_reg;
  wire fpga_reload_reg, flash_miso;
  logic [2:0] seen_cs;
  logic clr_cs = 1'b0;
  logic [15:0] sram [0:NW-1];
  logic [15:0] s, r;
  int err_count = 0;
  int total_checks = 0;
  int seed = 32'h11b5;
  int k, n, j;
  crps_sequencer #(.IMAGE_WORDS(NW), .FW_VERSION(FW)) i_crps_sequencer (.mclk, .srst,
    .reg_addr, .reg_wr, .reg_wdata, .reg_rd_data, .sram_addr_reg, .sram_rd_reg,
    .sram_we_reg, .sram_wdata_reg, .sram_rdata, .sram_host_sel_reg, .flash_cs_n_reg,
    .flash_sclk_reg, .flash_mosi_reg, .flash_miso, .fpga_reload_reg);
  crps_flash_model i_crps_flash_model (.cs_n(flash_cs_n_reg), .sclk(flash_sclk_reg),
    .mosi(flash_mosi_reg), .miso(flash_miso));
  initial begin
    forever #25 mclk = ~mclk;
  end
  // sram: data valid only the cycle after the strobe
  always @(posedge mclk) begin
    sram_rdata <= sram_rd_reg ? sram[sram_addr_reg[1:0]] : ~sram_rdata;
    if (sram_we_reg) sram[sram_addr_reg[1:0]] <= sram_wdata_reg;
    seen_cs <= clr_cs ? 3'h0 : (seen_cs | ~flash_cs_n_reg);
  end
  function automatic logic [15:0] exp_rd(input int w);
    return {8'h3C ^ 8'(2 * w), 8'h3C ^ 8'(2 * w + 1)};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s: got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge mclk) #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    @(posedge mclk) #1;
    reg_wr = 0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge mclk) #1;
    reg_addr = a;
    @(posedge mclk) #1;
    d = reg_rd_data;
  endtask
  // poll idle, bounded
  task automatic wait_idle;
    for (n = 0; n < 8000; n++) begin
      rd(5'h11, s);
      if (s[15] === 1'b1) return;
    end
    chk(s[15], 1'b1, "idle wait ran out");
    tally_and_finish;
  endtask
  // one opcode, with a stray execute edge while busy
  task automatic run(input logic [1:0] t, input logic [3:0] op);
    for (k = 0; k < NW; k++) sram[k] = $random(seed);
    wait_idle;
    wr(5'h06, {5'h00, t, 2'h0, op, 3'h0});
    clr_cs = 1'b1; // select history cleared before the start edge
    @(posedge mclk) #1;
    clr_cs = 1'b0;
    wr(5'h06, {5'h00, t, 2'h2, op, 3'h0});
    @(posedge mclk) #1;
    rd(5'h11, s);
    chk(s[15], 1'b0, "idle while busy");
    wr(5'h06, {5'h00, 2'h1, 2'h0, 4'h3, 3'h0});
    wr(5'h06, {5'h00, 2'h1, 2'h2, 4'h3, 3'h0});
    wait_idle;
    chk(seen_cs, 3'h1 << (t - 2'h1), "flash select");
    for (k = 0; k < NW; k++)
      if (op < 3) chk(i_crps_flash_model.mem[k], sram[k], "flash word");
      else chk(sram[k], exp_rd(k), "sram word");
    wr(5'h06, {5'h00, 2'h1, 2'h2, 4'h3, 3'h0});
    repeat (3) @(posedge mclk);
    rd(5'h11, s);
    chk(s, {1'b1, FW}, "held execute");
    wr(5'h06, {5'h00, t, 2'h0, op, 3'h0});
    $display("op %h done", op);
  endtask
  task automatic reboot(input logic [11:0] ks, input logic e);
    for (k = 3; k >= 1; k--) begin
      r = $random(seed);
      wr(5'h07, {r[15:3], ks[3*k +: 3]});
    end
    // last key write by hand so the pulse is counted from its first cycle
    r = $random(seed);
    @(posedge mclk) #1;
    reg_addr = 5'h07;
    reg_wdata = {r[15:3], ks[2:0]};
    reg_wr = 1;
    r = 16'h0000;
    repeat (30) begin
      @(posedge mclk) #1;
      reg_wr = 0;
      r = r + fpga_reload_reg;
    end
    chk(r, e ? 16'h0014 : 16'h0000, "reload cycles");
    $display("reboot %h done", ks);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    #1 srst = 0;
    rd(5'h11, s);
    chk(s, {1'b1, FW}, "status after reset");
    wr(5'h0C, 16'hFFFF);
    rd(5'h0C, s);
    chk(s, 16'h0000, "unmapped read");
    $display("reset test done");
    for (j = 0; j < 6; j++) run(2'(j % 3 + 1), 4'(j)); // one program and one readback per flash
    wr(5'h06, {5'h00, 2'h1, 2'h1, 4'h3, 3'h0});
    wr(5'h06, {5'h00, 2'h1, 2'h3, 4'h3, 3'h0});
    repeat (3) @(posedge mclk);
    rd(5'h11, s);
    chk({s[15], sram_host_sel_reg}, 2'h3, "sram select, no opcode");
    wr(5'h06, 16'h0000);
    $display("sram select done");
    wr(5'h06, {5'h00, 2'h0, 2'h0, 4'h0, 3'h0});
    wr(5'h06, {5'h00, 2'h0, 2'h2, 4'h0, 3'h0});
    repeat (3) @(posedge mclk);
    rd(5'h11, s);
    chk(s, {1'b1, FW}, "target zero started");
    wr(5'h06, {5'h00, 2'h1, 2'h0, 4'h6, 3'h0});
    wr(5'h06, {5'h00, 2'h1, 2'h2, 4'h6, 3'h0});
    repeat (3) @(posedge mclk);
    rd(5'h11, s);
    chk(s, {1'b1, FW}, "opcode six started");
    wr(5'h06, 16'h0000);
    $display("ignored command test done");
    reboot(12'h155, 1'b1);
    reboot(12'hA15, 1'b0);
    reboot(12'hB55, 1'b1);
    tally_and_finish;
  end
endmodule // tb
`default_nettype wire
